//--- core/peer_discovery_pkg.sv
// Package for the peer discovery engine: message layout, codes, timing.
// Assumes a 100 MHz system clock and byte-wide datagram streams.
package peer_discovery_pkg;
   // Discovery port and payload signature "networked_automation_port"
   localparam logic [15:0] disc_udp_port = 16'h1049;
   localparam logic [31:0] sig_word = 32'h69414454;
   localparam int msg_len = 12;
   // Byte positions
   localparam logic [3:0] pos_kind = 4'h4;
   localparam logic [3:0] pos_role = 4'h5;
   localparam logic [3:0] pos_len_hi = 4'h6;
   localparam logic [3:0] pos_len_lo = 4'h7;
   localparam logic [3:0] pos_rev = 4'h8;
   localparam logic [3:0] pos_flags = 4'h9;
   localparam int flag_unsecured_accept_flag_bit = 7;
   localparam int flag_tls_bit = 6;
   // Message kinds
   localparam logic [7:0] kind_announce = 8'h00;
   localparam logic [7:0] kind_response = 8'h01;
   // Device roles
   localparam logic [7:0] role_drive_device = 8'h00;
   localparam logic [7:0] role_automation = 8'h01;
   localparam logic [7:0] role_monitor = 8'h02;
   // Additional length sent: four bytes follow (bytes 8..11)
   localparam logic [15:0] add_len = 16'h0004;
   // Timing
   localparam int clk_mhz = 100;
   localparam int period_s = 3;
   localparam int cycles_per_ms = clk_mhz * 1000;
   localparam int max_delay_ms = 3000;
   localparam logic [31:0] lfsr_seed_rst = 32'h1;
   localparam logic [15:0] max_count_rst = 16'h0010;
endpackage

//--- core/peer_service_discovery.sv
// Peer discovery engine: announces, answers and tracks discovery datagrams.
// Assumes a UDP stack delivering/accepting payload bytes with peer address.
// Function
// R01: Once IP address present, broadcast and keep receiving on UDP port 4169.
// R02: Payload starts with four-byte ASCII signature in bytes 0-3.
// R03: Byte 4 kind: 00h announcement, 01h response, others reserved.
// R04: Byte 5 role: 00h drive, 01h automation, 02h monitor, others reserved.
// R05: Bytes 6-7 big-endian length of following bytes, multiple of four.
// R06: Byte 8 holds login major and minor revision.
// R07: Unsecured-accept flag set only if unsecured connections accepted.
// R08: Secure-transport flag set only if secure connections accepted; port configurable.
// R09: Random 0-3 s delay, broadcast every 3 s until addressed or count reached.
// R10: Broadcast messages carry kind 00h.
// R11: Announcement from other type: store sender, random delay, reply kind 01h.
// R12: Response not monitor nor own type: stop broadcasting, store sender.
// R13: Kind and role fields select announcement or response path.
// R14: Bad signature or reserved kind is silently dropped.
// R15: Free-running seeded pseudo-random source provides delays.
`timescale 1ns/1ns
module peer_service_discovery
   import peer_discovery_pkg::*;
#(
   parameter int max_delay_cycles = max_delay_ms * cycles_per_ms,
   parameter int period_cycles = period_s * 1000 * cycles_per_ms
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Configuration
   input wire logic ip_valid,
   input wire logic [7:0] own_role,
   input wire logic [7:0] login_revision,
   input wire logic unsecured_accept_flag_accept,
   input wire logic secure_accept,
   input wire logic [15:0] secure_port,
   input wire logic [15:0] max_messages,
   input wire logic [31:0] rand_seed,
   // Receive byte stream
   input wire logic rx_valid,
   input wire logic rx_first,
   input wire logic rx_last,
   input wire logic [7:0] rx_data,
   input wire logic [15:0] rx_dst_port,
   input wire logic [31:0] rx_src_ip,
   input wire logic [15:0] rx_src_port,
   // Transmit byte stream
   output logic tx_valid,
   input wire logic tx_ready,
   output logic tx_first,
   output logic tx_last,
   output logic [7:0] tx_data,
   output logic tx_broadcast,
   output logic [31:0] tx_dst_ip,
   output logic [15:0] tx_dst_port,
   output logic [15:0] tx_src_port,
   // Status
   output logic bcast_active,
   output logic peer_found,
   output logic [31:0] peer_ip,
   output logic [15:0] peer_port
);

   typedef enum {b_idle, b_wait, b_done} bcast_state_t;
   typedef enum {t_idle, t_send} tx_state_t;

   // Advance a 32-bit Galois LFSR
   // Taps give a long sequence; a nonzero state never reaches zero
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      lfsr_next = {1'b0, v[31:1]} ^ (v[0] ? 32'h80200003 : 32'h0);
   endfunction

   // Random delay from zero up to and including the 3 s bound
   function automatic logic [31:0] rand_delay(input logic [31:0] v);
      rand_delay = v % 32'(max_delay_cycles + 1);
   endfunction

   // Signature byte by position; shared by receive check and transmit mux
   function automatic logic [7:0] sig_at(input logic [1:0] i);
      sig_at = sig_word[8'(31 - 8 * int'(i)) -: 8];
   endfunction

   // Random source, broadcast schedule and transmit state
   logic [31:0] lfsr_q;
   bcast_state_t bst_q;
   tx_state_t tst_q;
   logic [31:0] btimer_q;
   logic [15:0] sent_q;
   logic bcast_due_q;

   // Pending reply
   logic resp_pend_q;
   logic [31:0] rtimer_q;
   logic resp_due_q;
   logic [31:0] resp_ip_q;
   logic [15:0] resp_port_q;

   // Receive tracking
   logic [3:0] rx_idx_q;
   logic rx_ok_q;
   logic [7:0] rx_kind_q;
   logic [7:0] rx_role_q;

   // Transmit sequencing and peer record
   logic [3:0] tx_idx_q;
   logic tx_is_resp_q;
   logic peer_found_q;
   logic [31:0] peer_ip_q;
   logic [15:0] peer_port_q;

   // Receive checks on each byte
   wire rx_here = rx_valid && ip_valid && (rx_dst_port == disc_udp_port); // R01
   wire [3:0] rx_pos = rx_first ? 4'h0 : rx_idx_q;
   wire [7:0] sig_byte = sig_at(rx_pos[1:0]);
   // A bad signature byte fails the datagram for good
   wire sig_ok = (rx_pos > 4'h3) || (rx_data == sig_byte); // R02 R14
   wire byte_ok = (rx_first || rx_ok_q) && sig_ok;
   wire [7:0] kind_now = (rx_pos == pos_kind) ? rx_data : rx_kind_q;
   wire [7:0] role_now = (rx_pos == pos_role) ? rx_data : rx_role_q;
   // Whole message judged at its last byte; short ones never reach byte 5
   wire rx_done = rx_here && rx_last && byte_ok && (rx_pos >= pos_role);
   // Announcements from a peer of another type earn a reply
   wire is_announce = rx_done && (kind_now == kind_announce) && (role_now != own_role); // R11 R13
   // Responses from a non-monitor peer of another type end the search
   wire is_response = rx_done && (kind_now == kind_response) && (role_now != role_monitor)
      && (role_now != own_role); // R12 R13

   // Receive byte tracking
   // Index saturates so an overlong datagram cannot wrap into the header
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_idx_q <= 4'h0;
         rx_ok_q <= 1'b0;
         rx_kind_q <= 8'hff;
         rx_role_q <= 8'hff;
      end else if (rx_here) begin
         rx_idx_q <= (rx_pos == 4'hf) ? rx_pos : rx_pos + 4'h1;
         rx_ok_q <= byte_ok && !rx_last;
         rx_kind_q <= rx_first ? 8'hff : kind_now;
         rx_role_q <= rx_first ? 8'hff : role_now;
      end
   end

   // Free-running random source; the seed is taken in reset so that ports
   // powered up together still pick different delays
   always_ff @(posedge clk) begin
      if (sys_rst)
         lfsr_q <= (rand_seed != 32'h0) ? rand_seed : lfsr_seed_rst; // R15
      else
         lfsr_q <= lfsr_next(lfsr_q); // R15
   end

   // Transmit handshake and slot choice; a due reply goes before a broadcast
   wire tx_take = tx_valid && tx_ready;
   wire tx_end = tx_take && tx_last;
   wire tx_start = (tst_q == t_idle) && (bcast_due_q || resp_due_q);
   wire start_resp = tx_start && resp_due_q;
   wire start_bcast = tx_start && !resp_due_q && bcast_due_q;
   // Vendor limit reached by the broadcast now starting
   wire count_hit = (sent_q + 16'h1) >= max_messages;

   // Broadcast schedule
   // Losing the address drops the schedule; regaining it starts afresh
   always_ff @(posedge clk) begin
      if (sys_rst || !ip_valid) begin
         bst_q <= b_idle;
         btimer_q <= 32'h0;
         sent_q <= 16'h0;
         bcast_due_q <= 1'b0;
      end else begin
         case (bst_q)
            b_idle: begin
               // Fresh random start each time the address is gained
               btimer_q <= rand_delay(lfsr_q); // R09
               bst_q <= b_wait; // R01
            end
            b_wait: begin
               if (is_response) begin
                  bst_q <= b_done; // R12
                  bcast_due_q <= 1'b0;
               end else if (btimer_q != 32'h0)
                  // Count down; an expired slot then waits while a reply holds the link
                  btimer_q <= btimer_q - 32'h1;
               else if (!bcast_due_q) begin
                  bcast_due_q <= 1'b1; // R09
                  btimer_q <= 32'(period_cycles - 1);
               end
               if (start_bcast) begin
                  bcast_due_q <= 1'b0;
                  sent_q <= sent_q + 16'h1;
                  if (count_hit)
                     bst_q <= b_done; // R09
               end
            end
            b_done: bst_q <= b_done;
            default: bst_q <= b_idle;
         endcase
      end
   end

   // Pending response with its own random delay
   // One reply at a time; a second announcement meanwhile is ignored
   always_ff @(posedge clk) begin
      if (sys_rst || !ip_valid) begin
         resp_pend_q <= 1'b0;
         resp_due_q <= 1'b0;
         rtimer_q <= 32'h0;
         resp_ip_q <= 32'h0;
         resp_port_q <= 16'h0;
      end else begin
         if (is_announce && !resp_pend_q) begin
            resp_pend_q <= 1'b1; // R11
            resp_ip_q <= rx_src_ip;
            resp_port_q <= rx_src_port;
            rtimer_q <= rand_delay(lfsr_q);
         end else if (resp_pend_q && !resp_due_q) begin
            // Delay counted down, then the reply waits for the sequencer
            if (rtimer_q == 32'h0)
               resp_due_q <= 1'b1;
            else
               rtimer_q <= rtimer_q - 32'h1;
         end
         if (start_resp) begin
            resp_due_q <= 1'b0;
            resp_pend_q <= 1'b0;
         end
      end
   end

   // Peer record from a matching response
   // Sticky until reset, even across a lost address
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         peer_found_q <= 1'b0;
         peer_ip_q <= 32'h0;
         peer_port_q <= 16'h0;
      end else if (is_response) begin
         peer_found_q <= 1'b1; // R12
         peer_ip_q <= rx_src_ip;
         peer_port_q <= rx_src_port;
      end
   end

   // Transmit sequencer
   // Destination IP latched at the start so it stands for the whole frame
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tst_q <= t_idle;
         tx_idx_q <= 4'h0;
         tx_is_resp_q <= 1'b0;
         tx_dst_ip <= 32'h0;
      end else begin
         case (tst_q)
            t_idle: if (tx_start) begin
               tst_q <= t_send;
               tx_idx_q <= 4'h0;
               tx_is_resp_q <= resp_due_q;
               tx_dst_ip <= resp_due_q ? resp_ip_q : 32'hffffffff;
            end
            t_send: begin
               // Index steps only on an accepted byte
               if (tx_end)
                  tst_q <= t_idle;
               else if (tx_take)
                  tx_idx_q <= tx_idx_q + 4'h1;
            end
            default: tst_q <= t_idle;
         endcase
      end
   end

   // Outgoing byte mux
   // Fixed twelve-byte layout; the length field always says four
   logic [7:0] tx_byte;
   always_comb begin
      case (tx_idx_q)
         4'h0, 4'h1, 4'h2, 4'h3: tx_byte = sig_at(tx_idx_q[1:0]); // R02
         pos_kind: tx_byte = tx_is_resp_q ? kind_response : kind_announce; // R10 R11 R03
         pos_role: tx_byte = own_role; // R04
         pos_len_hi: tx_byte = add_len[15:8]; // R05
         pos_len_lo: tx_byte = add_len[7:0]; // R05
         pos_rev: tx_byte = login_revision; // R06
         pos_flags: tx_byte = {unsecured_accept_flag_accept, secure_accept, 6'h0}; // R07 R08
         default: tx_byte = 8'h00;
      endcase
   end

   // Stream outputs
   // Handshake outputs decode the state; bytes stand until taken
   assign tx_valid = (tst_q == t_send);
   assign tx_first = tx_valid && (tx_idx_q == 4'h0);
   assign tx_last = tx_valid && (tx_idx_q == 4'(msg_len - 1));
   assign tx_data = tx_byte;
   assign tx_broadcast = tx_valid && !tx_is_resp_q;
   assign tx_dst_port = tx_is_resp_q ? resp_port_q : disc_udp_port;
   assign tx_src_port = disc_udp_port;
   // Status
   assign bcast_active = (bst_q == b_wait);
   assign peer_found = peer_found_q;
   assign peer_ip = peer_ip_q;
   assign peer_port = peer_port_q;

   // Secure port is carried for the stack; this engine only flags it
   // The secure listener number is still open, so it stays a plain input
   wire unused_port = ^secure_port;

endmodule // peer_service_discovery

//--- verif/peer_service_discovery_properties.sv
// Checker for the discovery engine: transmit framing and peer status.
// Assumes binding to the top module ports, one clock domain.
`timescale 1ns/1ns
module peer_service_discovery_properties
   import peer_discovery_pkg::*;
(
   // Clock, reset and configuration
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] login_revision,
   input wire logic unsecured_accept_flag_accept,
   input wire logic secure_accept,
   // Transmit stream and status
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic tx_first,
   input wire logic tx_last,
   input wire logic [7:0] tx_data,
   input wire logic tx_broadcast,
   input wire logic [31:0] tx_dst_ip,
   input wire logic [15:0] tx_src_port,
   input wire logic bcast_active,
   input wire logic peer_found
);
   logic [3:0] idx_q;
   logic [3:0] idx_d;
   // Byte position on the wire, cleared after each final byte
   assign idx_d = (tx_valid && tx_ready && tx_last) ? 4'h0 : idx_q + 4'h1;
   always_ff @(posedge clk) begin
      if (sys_rst)
         idx_q <= 4'h0;
      else if (tx_valid && tx_ready)
         idx_q <= idx_d;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_at(logic [3:0] n);
      tx_valid && idx_q == n;
   endsequence
   property p_first; tx_valid && tx_first |-> idx_q == 4'h0 && tx_data == 8'h69; endproperty
   a_first: assert property (p_first) else $error("bad first byte");
   property p_kind; s_at(4'h4) |-> tx_data == (tx_broadcast ? kind_announce : kind_response); endproperty
   a_kind: assert property (p_kind) else $error("bad kind byte");
   property p_last; tx_valid && tx_last |-> idx_q == 4'hb; endproperty
   a_last: assert property (p_last) else $error("bad frame length");
   property p_rev; s_at(4'h8) |-> tx_data == login_revision; endproperty
   a_rev: assert property (p_rev) else $error("bad revision byte");
   property p_flags; s_at(4'h9) |-> tx_data == {unsecured_accept_flag_accept, secure_accept, 6'h00}; endproperty
   a_flags: assert property (p_flags) else $error("bad flag byte");
   property p_bcast; tx_valid && tx_broadcast |-> tx_dst_ip == 32'hffffffff; endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast not to all");
   property p_port; tx_valid |-> tx_src_port == disc_udp_port; endproperty
   a_port: assert property (p_port) else $error("bad source port");
   property p_found; peer_found |=> peer_found && !bcast_active; endproperty
   a_found: assert property (p_found) else $error("found peer not kept");
   // A stalled byte stands unchanged; the frame ends at its last byte
   sequence s_stall;
      tx_valid && !tx_ready;
   endsequence
   sequence s_final;
      tx_valid && tx_ready && tx_last;
   endsequence
   property p_hold; s_stall |=> tx_valid && $stable(tx_data) && $stable(tx_last); endproperty
   a_hold: assert property (p_hold) else $error("stalled byte changed");
   property p_gap; s_final |=> !tx_valid; endproperty
   a_gap: assert property (p_gap) else $error("frame ran past last byte");
endmodule // peer_service_discovery_properties
bind peer_service_discovery peer_service_discovery_properties chk_u (.clk(clk), .sys_rst(sys_rst),
   .login_revision(login_revision), .unsecured_accept_flag_accept(unsecured_accept_flag_accept), .secure_accept(secure_accept),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_first(tx_first), .tx_last(tx_last), .tx_data(tx_data),
   .tx_broadcast(tx_broadcast), .tx_dst_ip(tx_dst_ip), .tx_src_port(tx_src_port),
   .bcast_active(bcast_active), .peer_found(peer_found));

//--- verif/peer_service_discovery_tb.sv
// Bench for the discovery engine: broadcast, refusal, answer, peer capture.
// Assumes shortened timing parameters and the remote port model.
`timescale 1ns/1ns
module peer_service_discovery_tb
   import peer_discovery_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ip_valid = 1'b0;
   logic [7:0] rev = 8'h23;
   logic unsecured_accept_flag = 1'b1;
   logic tls = 1'b0;
   logic [15:0] max_msgs = 16'h0002;
   logic rx_valid, rx_first, rx_last, tx_valid, tx_ready, tx_first, tx_last, tx_broadcast;
   logic bcast_active, peer_found;
   logic [7:0] rx_data, tx_data;
   logic [15:0] rx_dst_port, rx_src_port, tx_dst_port, tx_src_port, peer_port;
   logic [31:0] rx_src_ip, tx_dst_ip, peer_ip;
   int n_errors = 0;
   int total_checks = 0;
   // Clock
   initial begin
      forever #5 clk = ~clk;
   end
   peer_service_discovery #(.max_delay_cycles(50), .period_cycles(200)) dut_u (.clk(clk),
      .sys_rst(sys_rst), .ip_valid(ip_valid), .own_role(role_drive_device), .login_revision(rev),
      .unsecured_accept_flag_accept(unsecured_accept_flag), .secure_accept(tls), .secure_port(16'h1050), .max_messages(max_msgs),
      .rand_seed(32'h00001234), .rx_valid(rx_valid), .rx_first(rx_first), .rx_last(rx_last),
      .rx_data(rx_data), .rx_dst_port(rx_dst_port), .rx_src_ip(rx_src_ip), .rx_src_port(rx_src_port),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_first(tx_first), .tx_last(tx_last), .tx_data(tx_data),
      .tx_broadcast(tx_broadcast), .tx_dst_ip(tx_dst_ip), .tx_dst_port(tx_dst_port),
      .tx_src_port(tx_src_port), .bcast_active(bcast_active), .peer_found(peer_found),
      .peer_ip(peer_ip), .peer_port(peer_port));
   remote_port_model model_u (.clk(clk), .rx_valid(rx_valid), .rx_first(rx_first), .rx_last(rx_last),
      .rx_data(rx_data), .rx_dst_port(rx_dst_port), .rx_src_ip(rx_src_ip), .rx_src_port(rx_src_port),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_last(tx_last), .tx_data(tx_data),
      .tx_broadcast(tx_broadcast), .tx_dst_ip(tx_dst_ip));
   task automatic final_report;
      if (n_errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Bounded wait for n captured frames; a timeout ends the run
   task automatic wait_frames(input int n);
      int i;
      for (i = 0; i < 1000 && model_u.frames < n; i++)
         @(negedge clk);
      if (i == 1000) begin
         chk("frame timeout", n, model_u.frames);
         final_report;
      end
   endtask
   // Whole captured frame against the layout for this kind
   task automatic chk_frame(input logic [7:0] kind, input logic [31:0] ip);
      logic [95:0] m;
      m = {sig_word, kind, role_drive_device, add_len, rev, unsecured_accept_flag, tls, 6'h00, 16'h0000};
      for (int i = 0; i < 12; i++)
         chk("frame byte", m[95 - 8 * i -: 8], model_u.buf_q[i]);
      chk("destination", ip, model_u.last_ip);
   endtask
   task automatic t_broadcast;
      ip_valid = 1'b1;
      wait_frames(2);
      chk_frame(kind_announce, 32'hffffffff);
      chk("broadcast port", disc_udp_port, tx_dst_port);
      repeat (600) @(negedge clk);
      chk("frame count", 2, model_u.frames);
      chk("schedule", 1'b0, bcast_active);
   endtask
   task automatic t_refuse;
      model_u.slow = 1'b1;
      model_u.send_msg(32'h69414455, kind_announce, role_automation, 32'h0a000009);
      model_u.send_msg(sig_word, 8'h02, role_automation, 32'h0a000009);
      model_u.send_msg(sig_word, kind_announce, role_drive_device, 32'h0a000009);
      repeat (300) @(negedge clk);
      chk("refused count", 2, model_u.frames);
   endtask
   task automatic t_answer;
      model_u.send_msg(sig_word, kind_announce, role_automation, 32'h0a000005);
      wait_frames(3);
      chk_frame(kind_response, 32'h0a000005);
      chk("unicast", 1'b0, model_u.last_bc);
      chk("reply port", 16'h3039, tx_dst_port);
   endtask
   task automatic t_found;
      model_u.send_msg(sig_word, kind_response, role_monitor, 32'h0a000007);
      model_u.send_msg(sig_word, kind_response, role_drive_device, 32'h0a000007);
      repeat (5) @(negedge clk);
      chk("ignored peer", 1'b0, peer_found);
      model_u.send_msg(sig_word, kind_response, role_automation, 32'h0a000006);
      repeat (5) @(negedge clk);
      chk("peer found", 1'b1, peer_found);
      chk("peer address", 32'h0a000006, peer_ip);
      chk("peer port", 16'h3039, peer_port);
   endtask
   // Mid-run reset with new flags; a response then ends the schedule early
   task automatic t_restart;
      sys_rst = 1'b1;
      {rev, unsecured_accept_flag, tls, max_msgs} = {8'h14, 1'b0, 1'b1, 16'h0003};
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      chk("reset status", 1'b0, peer_found);
      wait_frames(4);
      chk_frame(kind_announce, 32'hffffffff);
      model_u.send_msg(sig_word, kind_response, role_automation, 32'h0a000008);
      repeat (600) @(negedge clk);
      chk("early stop", 4, model_u.frames);
      chk("stopped", 1'b0, bcast_active);
      chk("new peer", 32'h0a000008, peer_ip);
   endtask
   // Main sequence
   initial begin
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      t_broadcast();
      t_refuse();
      t_answer();
      t_found();
      t_restart();
      final_report();
   end
endmodule // peer_service_discovery_tb

//--- verif/remote_port_model.sv
// Remote discovery port: sends datagrams, drains and captures frames.
// Assumes the bench calls send_msg and reads the captured fields.
`timescale 1ns/1ns
module remote_port_model
   import peer_discovery_pkg::*;
(
   // Clock
   input wire logic clk,
   // Receive stream towards the engine
   output logic rx_valid,
   output logic rx_first,
   output logic rx_last,
   output logic [7:0] rx_data,
   output logic [15:0] rx_dst_port,
   output logic [31:0] rx_src_ip,
   output logic [15:0] rx_src_port,
   // Transmit stream from the engine
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic tx_last,
   input wire logic [7:0] tx_data,
   input wire logic tx_broadcast,
   input wire logic [31:0] tx_dst_ip
);
   logic slow = 1'b0;
   logic [7:0] buf_q [12];
   logic [3:0] n_q = 4'h0;
   int frames = 0;
   logic last_bc;
   logic [31:0] last_ip;
   // Idle stream; data carries no stale value
   initial begin
      {rx_valid, rx_first, rx_last} = 3'h0;
      {rx_data, rx_dst_port, rx_src_ip, rx_src_port} = '0;
      tx_ready = 1'b1;
   end
   // Stalls every other cycle when slow
   always @(negedge clk) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
   end
   // Capture each accepted byte and frame destination
   always @(posedge clk) begin
      if (tx_valid && tx_ready) begin
         buf_q[n_q] <= tx_data;
         n_q <= tx_last ? 4'h0 : n_q + 4'h1;
         if (tx_last) begin
            frames <= frames + 1;
            last_bc <= tx_broadcast;
            last_ip <= tx_dst_ip;
         end
      end
   end
   task automatic send_msg(input logic [31:0] sig, input logic [7:0] kind, input logic [7:0] role,
      input logic [31:0] ip);
      logic [95:0] m;
      m = {sig, kind, role, add_len, 8'h11, 8'h80, 16'h0000};
      for (int i = 0; i < 12; i++) begin
         @(negedge clk);
         {rx_valid, rx_first, rx_last} = {1'b1, i == 0, i == 11};
         {rx_dst_port, rx_src_ip, rx_src_port} = {disc_udp_port, ip, 16'h3039};
         rx_data = m[95 - 8 * i -: 8];
      end
      @(negedge clk);
      {rx_valid, rx_first, rx_last} = 3'h0;
      rx_data = ~rx_data;
      rx_src_ip = ~ip;
   endtask
endmodule // remote_port_model
